// file: logic/load_detect_pkg.sv
// Purpose: shared constants and types of the charging-port load detect
// Assumes: 25 MHz sys_clk; analog comparators arrive as plain levels
// Notes:   Contract list below names the pin behaviours the block keeps; the register map is not in it
//
// Contract
// - handover idle below 45mA >15s deasserts, 55mA
// - idle handover load over 55mA asserts flag
// - discharge output 2s, then high limit, flag held
// - handover monitoring only in mode code 0011
// - budgeting modes assert after low+25mA for 200ms
// - budgeting modes deassert after low-25mA for 3s
// - 1110 to 1111 switches without output discharge
// - flag modes keep actual limit at high setting
// - short present at enable enters constant current
// - thermal shutdown waits cooling, restarts, repeats
// - flag driven only in 0011, 0111, 1111
// - charging-downstream primary detection also asserts flag
package load_detect_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TICK_PERIOD_NS = 1000000;        // 1 ms time base
  localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ASSERT_MS      = 200;
  localparam int DEASSERT_MS    = 3000;
  localparam int IDLE_MS        = 15000;
  localparam int DISCH_MS       = 2000;
  localparam int TMR_W          = 16;
  // tick phase is unknown at start, so one extra tick guarantees the least
  localparam logic [TMR_W-1:0] ASSERT_TICKS   = TMR_W'(ASSERT_MS + 1);
  localparam logic [TMR_W-1:0] DEASSERT_TICKS = TMR_W'(DEASSERT_MS + 1);
  localparam logic [TMR_W-1:0] IDLE_TICKS     = TMR_W'(IDLE_MS + 1);
  localparam logic [TMR_W-1:0] DISCH_TICKS    = TMR_W'(DISCH_MS + 1);

  // ------------------------------------------------------------------
  // mode codes {mode_control_a, b, c, limit_select}
  // ------------------------------------------------------------------
  localparam logic [3:0] CODE_HANDOVER  = 4'h3;
  localparam logic [3:0] CODE_AUTO_DET  = 4'h7;
  localparam logic [3:0] CODE_ALT_STD   = 4'he;
  localparam logic [3:0] CODE_CDP       = 4'hf;
  localparam logic [2:0] CTL_DISCHARGE  = 3'h0;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int EVT_W  = 5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CLEAR  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATE  = 4'hc;
  localparam int EVT_FLAG_ON  = 0;
  localparam int EVT_FLAG_OFF = 1;
  localparam int EVT_THERMAL  = 2;
  localparam int EVT_SHORT    = 3;
  localparam int EVT_MODE     = 4;
  localparam logic [EVT_W-1:0] EVT_RESET = 5'h00;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    HO_CHARGE = 3'b001,
    HO_IDLE   = 3'b010,
    HO_DISCH  = 3'b100
  } handover_e;

  typedef enum logic [3:0] {
    SW_OFF = 4'b0001,
    SW_ON  = 4'b0010,
    SW_CC  = 4'b0100,
    SW_HOT = 4'b1000
  } switch_e;

  // mode pins as seen at the package
  typedef struct packed {
    logic mode_control_a;
    logic mode_control_b;
    logic mode_control_c;
    logic limit_select;
  } mode_pins_s;

  // analog comparator levels, all active high
  typedef struct packed {
    logic below_45ma;      // load under handover idle threshold
    logic above_55ma;      // load reached the 55mA handover limit
    logic above_lo_plus;   // load over low limit + 25mA
    logic below_lo_minus;  // load under low limit - 25mA
    logic at_limit;        // current limit loop is regulating
    logic over_temp;       // die above shutdown temperature
    logic cooled;          // die cooled by the hysteresis amount
    logic primary_detect;  // bc1.2 primary detection seen
  } sense_s;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  // detect codes where the flag is driven
  function automatic logic flag_code(input logic [3:0] code);
    flag_code = (code == CODE_HANDOVER) || (code == CODE_AUTO_DET) ||
                (code == CODE_CDP);
  endfunction

endpackage

// file: logic/pin_sync2.sv
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // ------------------------------------------------------------------
  // next values
  // ------------------------------------------------------------------
  always_comb
  begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // two stages, reset to all low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule

// file: logic/interval_timer.sv
// Purpose: counts time-base ticks while a condition holds
// Assumes: tick is a one-cycle pulse on sys_clk
// Notes:   count drops to zero the cycle after run falls
`timescale 1ns/1ps
module interval_timer
  import load_detect_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic [TMR_W-1:0] limit,
  output logic                  done
);

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  logic             done_nxt;

  // ------------------------------------------------------------------
  // count while run, saturate at limit
  // ------------------------------------------------------------------
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!run)
      cnt_nxt = '0;
    else if (tick && (cnt_r < limit))
      cnt_nxt = cnt_r + TMR_W'(1);
    done_nxt = run && (cnt_nxt >= limit);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      done  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done  <= done_nxt;
    end
  end

endmodule

// file: logic/charge_port_load_detect.sv
// Purpose: load flag, supply handover and switch control of a charge port
// Assumes: mode pins and comparators are asynchronous levels
// Notes:   time base is a 1 ms tick; TICK_CYCLES is a parameter for sims
`timescale 1ns/1ps
module charge_port_load_detect
  import load_detect_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire mode_pins_s        mode_pins,
  input  wire sense_s            sense,
  input  wire reg_req_s          reg_req,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   load_flag_n,
  output logic                   switch_on,
  output logic                   const_current,
  output logic                   output_discharge,
  output logic                   limit_55ma,
  output logic                   limit_high,
  output logic                   irq
);

  // ------------------------------------------------------------------
  // synchronised inputs
  // ------------------------------------------------------------------
  mode_pins_s mode_s;
  sense_s     sns;

  pin_sync2 #(.W($bits(mode_pins_s))) u_mode_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (mode_pins),
    .q       (mode_s)
  );

  pin_sync2 #(.W($bits(sense_s))) u_sense_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (sense),
    .q       (sns)
  );

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  logic [3:0] code;
  logic [3:0] code_r;
  logic       mode_chg;
  logic       ho_mode;
  logic       ppm_mode;
  logic       cdp_mode;
  logic       disch_code;
  logic       keep_out;

  assign code       = mode_s;
  assign mode_chg   = (code != code_r);
  assign ho_mode    = (code == CODE_HANDOVER);
  assign ppm_mode   = (code == CODE_AUTO_DET) || (code == CODE_CDP);
  assign cdp_mode   = (code == CODE_CDP);
  assign disch_code = (code[3:1] == CTL_DISCHARGE);
  // limit select toggling between 1110 and 1111 keeps the port up
  assign keep_out   = (code_r[3:1] == CODE_ALT_STD[3:1]) &&
                      (code[3:1] == CODE_ALT_STD[3:1]);

  // ------------------------------------------------------------------
  // time base
  // ------------------------------------------------------------------
  logic [TMR_W-1:0] pre_r;
  logic [TMR_W-1:0] pre_nxt;
  logic             tick_r;
  logic             tick_nxt;

  // prescaler wraps every TICK_CYCLES clocks and emits one tick
  always_comb
  begin
    tick_nxt = (pre_r == TMR_W'(TICK_CYCLES - 1));
    pre_nxt  = tick_nxt ? '0 : pre_r + TMR_W'(1);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      pre_r  <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ------------------------------------------------------------------
  // interval timers
  // ------------------------------------------------------------------
  handover_e ho_r;
  handover_e ho_nxt;
  logic      ppm_flag_r;
  logic      ppm_flag_nxt;
  logic      run_asrt;
  logic      run_deas;
  logic      run_idle;
  logic      run_disch;
  logic      asrt_done;
  logic      deas_done;
  logic      idle_done;
  logic      disch_done;

  // a mode change zeroes every timer for one cycle
  assign run_asrt  = !mode_chg && ppm_mode && !ppm_flag_r &&
                     sns.above_lo_plus;
  assign run_deas  = !mode_chg && ppm_mode && ppm_flag_r &&
                     sns.below_lo_minus;
  assign run_idle  = !mode_chg && ho_mode && (ho_r == HO_CHARGE) &&
                     sns.below_45ma;
  assign run_disch = !mode_chg && ho_mode && (ho_r == HO_DISCH);

  interval_timer u_t_asrt (
    .sys_clk (sys_clk), .rst_n (rst_n), .tick (tick_r),
    .run (run_asrt), .limit (ASSERT_TICKS), .done (asrt_done)
  );
  interval_timer u_t_deas (
    .sys_clk (sys_clk), .rst_n (rst_n), .tick (tick_r),
    .run (run_deas), .limit (DEASSERT_TICKS), .done (deas_done)
  );
  interval_timer u_t_idle (
    .sys_clk (sys_clk), .rst_n (rst_n), .tick (tick_r),
    .run (run_idle), .limit (IDLE_TICKS), .done (idle_done)
  );
  interval_timer u_t_disch (
    .sys_clk (sys_clk), .rst_n (rst_n), .tick (tick_r),
    .run (run_disch), .limit (DISCH_TICKS), .done (disch_done)
  );

  // ------------------------------------------------------------------
  // supply handover and budgeting flag
  // ------------------------------------------------------------------
  always_comb
  begin
    ho_nxt = ho_r;
    if (!ho_mode)
      ho_nxt = HO_CHARGE;
    else
    begin
      case (ho_r)
        HO_CHARGE: if (idle_done)       ho_nxt = HO_IDLE;
        HO_IDLE:   if (sns.above_55ma)  ho_nxt = HO_DISCH;
        HO_DISCH:  if (disch_done)      ho_nxt = HO_CHARGE;
        default:                        ho_nxt = HO_CHARGE;
      endcase
    end
    // set beats the deassert clear; a mode change other than within 1110/1111 or a non-budgeting code clears over both
    ppm_flag_nxt = ppm_flag_r;
    if (deas_done)
      ppm_flag_nxt = 1'b0;
    if (asrt_done || (cdp_mode && sns.primary_detect))
      ppm_flag_nxt = 1'b1;
    if (!ppm_mode || (mode_chg && !keep_out))
      ppm_flag_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ho_r       <= HO_CHARGE;
      ppm_flag_r <= 1'b0;
      code_r     <= '0;
    end
    else
    begin
      ho_r       <= ho_nxt;
      ppm_flag_r <= ppm_flag_nxt;
      code_r     <= code;
    end
  end

  // ------------------------------------------------------------------
  // power switch control
  // ------------------------------------------------------------------
  switch_e sw_r;
  switch_e sw_nxt;
  logic    en_req;

  // handover discharge also counts as a disabled port
  assign en_req = !disch_code && !(ho_mode && (ho_nxt == HO_DISCH));

  always_comb
  begin
    sw_nxt = sw_r;
    case (sw_r)
      SW_OFF:
        if (sns.over_temp)       sw_nxt = SW_HOT;
        else if (en_req)
          sw_nxt = sns.at_limit ? SW_CC : SW_ON;
      SW_ON:
        if (sns.over_temp)       sw_nxt = SW_HOT;
        else if (!en_req)        sw_nxt = SW_OFF;
        else if (sns.at_limit)   sw_nxt = SW_CC;
      SW_CC:
        if (sns.over_temp)       sw_nxt = SW_HOT;
        else if (!en_req)        sw_nxt = SW_OFF;
        else if (!sns.at_limit)  sw_nxt = SW_ON;
      SW_HOT:
        // restart only after hysteresis; a live overload cycles again
        if (sns.cooled && !sns.over_temp)
          sw_nxt = en_req ? SW_ON : SW_OFF;
      default:                   sw_nxt = SW_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_r <= SW_OFF;
    else
      sw_r <= sw_nxt;
  end

  // ------------------------------------------------------------------
  // pin outputs
  // ------------------------------------------------------------------
  logic flag_n_nxt;
  logic lim55_nxt;
  logic limhi_nxt;
  logic disch_nxt;

  always_comb
  begin
    if (ho_mode)
      flag_n_nxt = (ho_nxt == HO_IDLE);
    else if (ppm_mode)
      flag_n_nxt = !ppm_flag_nxt;
    else
      flag_n_nxt = 1'b1;
    lim55_nxt = ho_mode && (ho_nxt == HO_IDLE);
    // flag thresholds use the low setting, the port stays on the high one
    limhi_nxt = code[0] || (code[3:2] == 2'b00 && code[1]) ||
                flag_code(code);
    disch_nxt = disch_code || (ho_mode && ho_nxt == HO_DISCH);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_flag_n      <= 1'b1;
      switch_on        <= 1'b0;
      const_current    <= 1'b0;
      output_discharge <= 1'b1;
      limit_55ma       <= 1'b0;
      limit_high       <= 1'b0;
    end
    else
    begin
      load_flag_n      <= flag_n_nxt;
      switch_on        <= (sw_nxt == SW_ON) || (sw_nxt == SW_CC);
      const_current    <= (sw_nxt == SW_CC);
      output_discharge <= disch_nxt;
      limit_55ma       <= lim55_nxt;
      limit_high       <= limhi_nxt;
    end
  end

  // ------------------------------------------------------------------
  // status, enable, clear and read-back
  // ------------------------------------------------------------------
  logic [EVT_W-1:0]  evt;
  logic [EVT_W-1:0]  stat_r;
  logic [EVT_W-1:0]  stat_nxt;
  logic [EVT_W-1:0]  ena_r;
  logic [EVT_W-1:0]  ena_nxt;
  logic [DATA_W-1:0] rdata_nxt;

  always_comb
  begin
    evt = '0;
    evt[EVT_FLAG_ON]  = load_flag_n && !flag_n_nxt;
    evt[EVT_FLAG_OFF] = !load_flag_n && flag_n_nxt;
    evt[EVT_THERMAL]  = (sw_r != SW_HOT) && (sw_nxt == SW_HOT);
    evt[EVT_SHORT]    = (sw_r == SW_OFF) && (sw_nxt == SW_CC);
    evt[EVT_MODE]     = mode_chg;
    stat_nxt = stat_r;
    ena_nxt  = ena_r;
    if (reg_req.wr && reg_req.addr == OFS_CLEAR)
      stat_nxt = stat_nxt & ~reg_req.wdata[EVT_W-1:0];
    if (reg_req.wr && reg_req.addr == OFS_ENABLE)
      ena_nxt = reg_req.wdata[EVT_W-1:0];
    stat_nxt = stat_nxt | evt;   // a new event wins over its clear
    rdata_nxt = '0;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        OFS_STATUS: rdata_nxt = DATA_W'(stat_r);
        OFS_ENABLE: rdata_nxt = DATA_W'(ena_r);
        OFS_STATE:  rdata_nxt = DATA_W'({sw_r, ho_r, code_r, ppm_flag_r,
                                         load_flag_n});
        default:    rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_r    <= EVT_RESET;
      ena_r     <= EVT_RESET;
      reg_rdata <= '0;
      irq       <= 1'b0;
    end
    else
    begin
      stat_r    <= stat_nxt;
      ena_r     <= ena_nxt;
      reg_rdata <= rdata_nxt;
      irq       <= |(stat_nxt & ena_nxt);
    end
  end

endmodule

// file: sim/load_detect_props.sv
// Purpose: port-level properties of the charge port load detect
// Assumes: a pin edge reaches the outputs three clock edges later
// Notes:   raw-pin counters run ahead of the synced timers
`timescale 1ns/1ps
module load_detect_props
  import load_detect_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire mode_pins_s mode_pins,
  input  wire sense_s     sense,
  input  wire logic       load_flag_n,
  input  wire logic       switch_on,
  input  wire logic       const_current,
  input  wire logic       output_discharge,
  input  wire logic       limit_55ma,
  input  wire logic       limit_high
);
  localparam int IDLE_MIN   = IDLE_MS * TICK_CYCLES;
  localparam int ASSERT_MIN = ASSERT_MS * TICK_CYCLES;
  localparam int DISCH_MIN  = DISCH_MS * TICK_CYCLES;

  int below_r;
  int above_r;
  int disch_r;
  int below_nxt;
  int above_nxt;
  int disch_nxt;

  // --------------------------------------------------------------
  // helper counters of raw condition time
  // --------------------------------------------------------------
  always_comb
  begin
    below_nxt = (sense.below_45ma && mode_pins == CODE_HANDOVER) ?
                below_r + 1 : 0;
    above_nxt = (sense.above_lo_plus && mode_pins == CODE_AUTO_DET) ?
                above_r + 1 : 0;
    disch_nxt = output_discharge ? disch_r + 1 : 0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      below_r <= 0;
      above_r <= 0;
      disch_r <= 0;
    end
    else
    begin
      below_r <= below_nxt;
      above_r <= above_nxt;
      disch_r <= disch_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------
  // properties; six-sample windows cover sync plus register delay
  // --------------------------------------------------------------
  sequence s_idle_loaded;
    (limit_55ma && mode_pins == CODE_HANDOVER && sense.above_55ma) [*3];
  endsequence
  sequence s_wake_done;
    !load_flag_n && output_discharge;
  endsequence
  sequence s_recharge;
    switch_on && limit_high && !load_flag_n;
  endsequence

  property p_flag_off;
    (!flag_code(mode_pins)) [*6] |-> load_flag_n;
  endproperty
  property p_ho_only;
    (mode_pins != CODE_HANDOVER) [*6] |-> !limit_55ma;
  endproperty
  property p_hi_limit;
    (mode_pins == CODE_AUTO_DET || mode_pins == CODE_CDP) [*6]
      |-> limit_high;
  endproperty
  property p_primary;
    (mode_pins == CODE_CDP && sense.primary_detect) [*5]
      |-> ##[0:2] !load_flag_n;
  endproperty
  property p_no_disch;
    (mode_pins == CODE_ALT_STD && !output_discharge) [*4]
      ##1 (mode_pins == CODE_CDP) |-> !output_discharge [*6];
  endproperty
  property p_wake;
    s_idle_loaded |-> ##[0:2] s_wake_done;
  endproperty
  property p_disch_len;
    $fell(output_discharge) && mode_pins == CODE_HANDOVER
      |-> (disch_r >= DISCH_MIN) ##[0:2] s_recharge;
  endproperty
  property p_idle_time;
    $rose(limit_55ma) |-> load_flag_n && below_r >= IDLE_MIN;
  endproperty
  property p_assert_time;
    $fell(load_flag_n) && mode_pins == CODE_AUTO_DET &&
      $past(mode_pins, 6) == CODE_AUTO_DET |-> above_r >= ASSERT_MIN;
  endproperty
  property p_short;
    (mode_pins == CODE_AUTO_DET && sense.at_limit && sense.cooled &&
     !sense.over_temp && !switch_on) [*3]
      |-> ##[0:3] (switch_on && const_current);
  endproperty
  property p_hot_off;
    sense.over_temp [*5] |-> !switch_on;
  endproperty

  a_flag_off: assert property (p_flag_off)
    else $error("flag driven outside detect codes");
  a_ho_only: assert property (p_ho_only)
    else $error("55mA limit outside handover code");
  a_hi_limit: assert property (p_hi_limit)
    else $error("limit not high in detect code");
  a_primary: assert property (p_primary)
    else $error("primary detect missed");
  a_no_disch: assert property (p_no_disch)
    else $error("discharge on 1110 to 1111");
  a_wake: assert property (p_wake)
    else $error("idle load did not wake");
  a_disch_len: assert property (p_disch_len)
    else $error("discharge too short or no recharge");
  a_idle_time: assert property (p_idle_time)
    else $error("handover idle entered too early");
  a_assert_time: assert property (p_assert_time)
    else $error("flag asserted too early");
  a_short: assert property (p_short)
    else $error("short at enable not in constant current");
  a_hot_off: assert property (p_hot_off)
    else $error("switch on while hot");
endmodule

bind charge_port_load_detect load_detect_props #(
  .TICK_CYCLES(TICK_CYCLES)
) u_load_detect_props (
  .sys_clk         (sys_clk),
  .rst_n           (rst_n),
  .mode_pins       (mode_pins),
  .sense           (sense),
  .load_flag_n     (load_flag_n),
  .switch_on       (switch_on),
  .const_current   (const_current),
  .output_discharge(output_discharge),
  .limit_55ma      (limit_55ma),
  .limit_high      (limit_high)
);

// file: sim/sys_power_model.sv
// Purpose: system power controller and port load stand-in
// Assumes: one port; a sibling port's demand arrives as budget_full
// Notes:   load is a level in mA turned into comparator levels
`timescale 1ns/1ps
module sys_power_model
  import load_detect_pkg::*;
#(
  parameter int LO_MA = 500
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  req_code,
  input  wire logic        budget_full,
  input  wire logic        load_flag_n,
  input  wire logic [3:0]  misc,
  input  wire logic [15:0] load_ma,
  output mode_pins_s       mode_pins,
  output sense_s           sense
);
  mode_pins_s mode_nxt;
  sense_s     sense_nxt;

  // a port that holds the budget keeps it; others fall to low limit
  always_comb
  begin
    mode_nxt = req_code;
    if (budget_full && load_flag_n && req_code == CODE_CDP)
      mode_nxt = CODE_ALT_STD;
    sense_nxt = {load_ma < 16'd45, load_ma > 16'd55,
                 int'(load_ma) > LO_MA + 25,
                 int'(load_ma) < LO_MA - 25, misc};
  end

  // pins move just after an edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_pins <= '0;
      sense     <= '0;
    end
    else
    begin
      mode_pins <= mode_nxt;
      sense     <= sense_nxt;
    end
  end
endmodule

// file: sim/test_charge_port_load_detect.sv
// Purpose: self-checking bench of the charge port load detect
// Assumes: short time base; every ms figure becomes TK cycles
// Notes:   drivers queue expectations, one monitor compares them
`timescale 1ns/1ps
module test_charge_port_load_detect
  import load_detect_pkg::*;
;
  localparam int TK = 2;
  typedef enum logic [3:0] {RDT, FLG, DIS, L55, LHI, SW, CC, IRQ} kind_e;
  typedef struct packed {logic [3:0] k; logic [31:0] v;} note_s;

  logic        sys_clk;
  logic        rst_n;
  logic [3:0]  req_code;
  logic        budget_full;
  logic [3:0]  misc;
  logic [15:0] load_ma;
  reg_req_s    req;
  logic        probe;
  logic        rd_d = 1'b0;
  mode_pins_s  mode_pins;
  sense_s      sense;
  logic [31:0] reg_rdata;
  logic [6:0]  outs;
  note_s       q[$];
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;

  charge_port_load_detect #(.TICK_CYCLES(TK)) u_charge_port_load_detect (
    .sys_clk(sys_clk), .rst_n(rst_n), .mode_pins(mode_pins),
    .sense(sense), .reg_req(req), .reg_rdata(reg_rdata),
    .load_flag_n(outs[0]), .output_discharge(outs[1]),
    .limit_55ma(outs[2]), .limit_high(outs[3]), .switch_on(outs[4]),
    .const_current(outs[5]), .irq(outs[6]));
  sys_power_model u_sys_power_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_code(req_code),
    .budget_full(budget_full), .load_flag_n(outs[0]), .misc(misc),
    .load_ma(load_ma), .mode_pins(mode_pins), .sense(sense));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // drivers; each returns just after a rising edge
  // ----------------------------------------------------------------
  task automatic note(input logic [3:0] k, input logic [31:0] v);
    q.push_back({k, v});
    probe <= 1'b1;
    @(posedge sys_clk);
    probe <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back({4'h0, e});
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic ms(input int n);
    repeat (n * TK) @(posedge sys_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // read data stand only one cycle after the strobe
  always @(posedge sys_clk)
  begin : watch
    note_s       e;
    logic [31:0] got;
    rd_d <= req.rd;
    if (rd_d || probe)
    begin
      e = q.pop_front();
      got = (e.k == 4'h0) ? reg_rdata : {31'h0, outs[e.k - 4'h1]};
      tests_run++;
      if (got !== e.v)
      begin
        n_fail++;
        $display("[ERR] %0t kind %0d got %h exp %h", $time, e.k, got,
                 e.v);
      end
    end
  end

  // the scenarios need about 45k cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    probe = 1'b0;
    req_code = 4'h0;
    budget_full = 1'b0;
    misc = 4'b0010;
    load_ma = 16'd0;
    void'($urandom(32'h831a));
    ms(10);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(OFS_ENABLE, 32'h0);
    rd(4'h2, 32'h0);
    wr(OFS_STATUS, 32'h1f);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_ENABLE, 32'h1f);
    rd(OFS_ENABLE, 32'h1f);
    rd(OFS_CLEAR, 32'h0);
    // heavy load in the auto detect code
    req_code <= CODE_AUTO_DET;
    load_ma <= 16'(600 + $urandom_range(900));
    ms(195);
    note(FLG, 1);
    ms(10);
    note(FLG, 0);
    note(IRQ, 1);
    rd(OFS_STATUS, 32'h11);
    wr(OFS_CLEAR, 32'h1f);
    note(IRQ, 0);
    // light load; a blip between thresholds restarts the count
    load_ma <= 16'($urandom_range(400));
    ms(2000);
    load_ma <= 16'd500;
    ms(4);
    load_ma <= 16'd100;
    ms(2990);
    note(FLG, 0);
    ms(20);
    note(FLG, 1);
    // budget taken by another port, then released
    budget_full <= 1'b1;
    req_code <= CODE_CDP;
    ms(4);
    note(LHI, 0);
    budget_full <= 1'b0;
    ms(4);
    note(DIS, 0);
    note(LHI, 1);
    misc <= 4'b0011;
    ms(4);
    note(FLG, 0);
    // discharge code, then enable into a shorted output
    misc <= 4'b0010;
    req_code <= 4'h0;
    ms(4);
    note(FLG, 1);
    note(DIS, 1);
    wr(OFS_CLEAR, 32'h1f);
    wr(OFS_ENABLE, 32'h01);
    misc <= 4'b1010;
    req_code <= CODE_AUTO_DET;
    ms(4);
    note(CC, 1);
    note(SW, 1);
    note(IRQ, 0);
    misc <= 4'b0100;
    ms(4);
    note(SW, 0);
    misc <= 4'b0010;
    ms(4);
    note(SW, 1);
    wr(OFS_ENABLE, 32'h04);
    note(IRQ, 1);
    rd(OFS_STATUS, 32'h1c);
    wr(OFS_CLEAR, 32'h1c);
    rd(OFS_STATUS, 32'h0);
    note(IRQ, 0);
    // supply handover: charge, go idle, wake on load, discharge
    load_ma <= 16'd800;
    req_code <= CODE_HANDOVER;
    ms(4);
    note(FLG, 0);
    note(LHI, 1);
    load_ma <= 16'($urandom_range(40));
    ms(14990);
    note(FLG, 0);
    ms(20);
    note(FLG, 1);
    note(L55, 1);
    load_ma <= 16'(60 + $urandom_range(2000));
    ms(4);
    note(FLG, 0);
    note(DIS, 1);
    ms(1990);
    note(DIS, 1);
    ms(20);
    note(DIS, 0);
    note(SW, 1);
    note(FLG, 0);
    rd(OFS_STATE, 32'h44c);
    summarize();
  end
endmodule
